// ---- pkg/elpc_cfg.svh ----
`ifndef ELPC_CFG_SVH
`define ELPC_CFG_SVH

// Register offsets on the plain register port
`define ELPC_OFS_PEND_A 3'h0
`define ELPC_OFS_PEND_B 3'h1
`define ELPC_OFS_PEND_C 3'h2
`define ELPC_OFS_BRK_CTL 3'h3
`define ELPC_OFS_OPT_ONE 3'h4
`define ELPC_OFS_LP_STAT 3'h5

// Pending flag bit positions
`define ELPC_BIT_EXT_PIN 2
`define ELPC_BIT_CHAN0 4
`define ELPC_BIT_CHAN1 5
`define ELPC_BIT_OVERFLOW 6
`define ELPC_BIT_KEYPAD 7
`define ELPC_BIT_CONV_DONE 0

// Control and status bit positions
`define ELPC_BIT_CLR_PERMIT 7
`define ELPC_BIT_SHORT_REC 0
`define ELPC_BIT_WDOG_DIS 1
`define ELPC_BIT_LP_BREAK 1

// Number of maskable hardware sources
`define ELPC_NUM_HW 6

// Two-byte vector addresses, highest priority first
`define ELPC_VEC_RESET 16'hfffe
`define ELPC_VEC_TRAP 16'hfffc
`define ELPC_VEC_EXT_PIN 16'hfffa
`define ELPC_VEC_CHAN0 16'hfff6
`define ELPC_VEC_CHAN1 16'hfff4
`define ELPC_VEC_OVERFLOW 16'hfff2
`define ELPC_VEC_KEYPAD 16'hffe0
`define ELPC_VEC_CONV_DONE 16'hffde

// Stop recovery lengths in quad bus clock cycles
`define ELPC_REC_LONG_CYC 13'h1000
`define ELPC_REC_SHORT_CYC 13'h0020

`endif

// ---- pkg/elpc_pkg.sv ----
`default_nettype none
package elpc_pkg;

  // Arbitration result handed to the core, highest priority first except reset, which is coded last
  typedef enum logic [2:0] {
    ELPC_SRC_TRAP,
    ELPC_SRC_EXT_PIN,
    ELPC_SRC_CHAN0,
    ELPC_SRC_CHAN1,
    ELPC_SRC_OVERFLOW,
    ELPC_SRC_KEYPAD,
    ELPC_SRC_CONV_DONE,
    ELPC_SRC_RESET
  } elpc_src_type;

  typedef enum logic [1:0] {
    ELPC_ST_RUN,
    ELPC_ST_WAIT,
    ELPC_ST_STOP,
    ELPC_ST_RECOVER
  } elpc_mode_type;

endpackage : elpc_pkg
`default_nettype wire

// ---- pkg/elpc_rec_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface elpc_rec_if;
  logic hold;
  logic short_sel;
  logic done;
  modport ctl (output hold, output short_sel, input done);
  modport cnt (input hold, input short_sel, output done);
endinterface : elpc_rec_if
`default_nettype wire

// ---- hw/elpc_recovery_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "elpc_cfg.svh"
module elpc_recovery_counter (
  input wire logic clk,
  input wire logic sys_rst,
  elpc_rec_if.cnt rec
);
  import elpc_pkg::*;

  typedef struct packed {
    logic [12:0] cnt;
    logic done;
  } elpc_rc_state_type;

  elpc_rc_state_type q_ff;
  elpc_rc_state_type nxt_q;
  logic [12:0] limit;

  // Limit picked live; an option write during recovery changes it mid-count
  assign limit = rec.short_sel ? `ELPC_REC_SHORT_CYC : `ELPC_REC_LONG_CYC;

  // Held clear for the whole stop, counts only once recovery begins
  always_comb begin
    nxt_q = q_ff;
    nxt_q.done = 1'b0;
    if (rec.hold) begin
      nxt_q.cnt = 13'h0000;
    end else if (q_ff.cnt == limit - 13'h0001) begin
      nxt_q.done = 1'b1;
      nxt_q.cnt = 13'h0000;
    end else begin
      nxt_q.cnt = q_ff.cnt + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rec.done = q_ff.done;

endmodule : elpc_recovery_counter
`default_nettype wire

// ---- hw/elpc_exc_ctl.sv ----
// How it works
// - Latch requests, arbitrate at service start, hand the core a vector code.
// - A latched request stays until serviced or its request is withdrawn while unmasked.
// - Entry tells the core to stack and set mask; return unstacks.
// - Hardware requests wait for instruction end, mask clear and source enable.
// - Several pending at a boundary: highest priority wins.
// - Request still pending at return is taken before the next main instruction.
// - The high index byte is never stacked on entry.
// - Software trap and break ignore the global mask; hardware obeys it in run only, not at wait wake or stop recovery.
// - Trap stacks PC, hardware entry stacks PC minus one.
// - Fixed priority order with its own two-byte vector per source.
// - Each maskable source's pending flag reads its live request.
// - Unused bits of the three pending registers read zero.
// - Reset outranks everything and skips arbitration.
// - Break request forces the core to the trap vector, entering break state.
// - In break state other modules may clear flags only with the permit bit.
// - A flag cleared during break stays cleared after break ends.
// - Two-step flag clears stay blocked during break, normal after it.
// - Wait or stop clears the global mask and stops the core clock.
// - Wait keeps peripherals clocked; enabled request wakes, stacking next cycle.
// - Reset or break end wait; break sets low-power flag; watchdog per option.
// - Stop gates oscillators, holds counter; wake event then times recovery.
// - Recovery is 4096 quad clocks, or 32 with short recovery selected.
`timescale 1ns/1ps
`default_nettype none
`include "elpc_cfg.svh"
module elpc_exc_ctl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] src_req,
  input wire logic [5:0] src_en,
  input wire logic glob_mask,
  input wire logic instr_done,
  input wire logic trap_exec,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic return_done,
  input wire logic vector_taken,
  input wire logic break_req,
  output logic int_req,
  output elpc_pkg::elpc_src_type int_src,
  output logic [15:0] vec_addr,
  output logic stack_pc_minus_one,
  output logic stack_index_high,
  output logic mask_clear,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic break_state,
  output logic flag_clear_permit,
  output logic watchdog_active
);
  import elpc_pkg::*;

  // All state in one record: one comb copy, one register
  typedef struct packed {
    elpc_mode_type mode;
    logic lat_vld;
    elpc_src_type lat_src;
    logic brk_st;
    logic brk_pend;
    logic clr_permit_bit;
    logic short_rec;
    logic wdog_dis;
    logic lp_flag;
    logic [7:0] rdata;
    logic mask_clr;
    logic core_en;
    logic periph_en;
    logic osc_on;
    logic permit;
    logic wdog_act;
    logic [15:0] vec;
    logic pc_m1;
  } elpc_state_type;

  // State register and its next value
  elpc_state_type q_ff;
  elpc_state_type nxt_q;
  // Live request view, sleep-time break and recovery handshake
  logic [5:0] hw_act;
  logic any_hw;
  elpc_src_type hw_pick;
  logic lp_set;
  logic rec_done_w;

  // Private link to the recovery counter
  elpc_rec_if rec_bus ();

  // Fixed-priority pick, lowest index highest
  function automatic elpc_src_type pick_src(input logic [5:0] act);
    elpc_src_type r;
    r = ELPC_SRC_CONV_DONE;
    for (int i = `ELPC_NUM_HW - 1; i >= 0; i--) begin
      if (act[i]) begin
        r = elpc_src_type'(3'(i + 1));
      end
    end
    return r;
  endfunction : pick_src

  // Vector table lookup
  function automatic logic [15:0] vec_of(input elpc_src_type s);
    logic [15:0] v;
    unique case (s)
      ELPC_SRC_TRAP: v = `ELPC_VEC_TRAP;
      ELPC_SRC_EXT_PIN: v = `ELPC_VEC_EXT_PIN;
      ELPC_SRC_CHAN0: v = `ELPC_VEC_CHAN0;
      ELPC_SRC_CHAN1: v = `ELPC_VEC_CHAN1;
      ELPC_SRC_OVERFLOW: v = `ELPC_VEC_OVERFLOW;
      ELPC_SRC_KEYPAD: v = `ELPC_VEC_KEYPAD;
      ELPC_SRC_CONV_DONE: v = `ELPC_VEC_CONV_DONE;
      ELPC_SRC_RESET: v = `ELPC_VEC_RESET;
    endcase
    return v;
  endfunction : vec_of

  // Live requests gated by their own enables; the mask is applied separately
  assign hw_act = src_req & src_en;
  assign any_hw = |hw_act;
  assign hw_pick = pick_src(hw_act);

  // Break seen while the core sleeps; beats a clear of the flag in the same cycle
  assign lp_set = break_req && (q_ff.mode != ELPC_ST_RUN);

  // Counter held for the whole stop, released only for recovery
  assign rec_bus.hold = (q_ff.mode != ELPC_ST_RECOVER);
  assign rec_bus.short_sel = q_ff.short_rec;
  assign rec_done_w = rec_bus.done;

  // Counts quad clock cycles; clk stands in for that clock here
  elpc_recovery_counter u_rec (
    .clk(clk),
    .sys_rst(sys_rst),
    .rec(rec_bus)
  );

  // Next state: retire, arbitrate, sequence low power, then registers
  always_comb begin
    nxt_q = q_ff;
    nxt_q.mask_clr = 1'b0;
    nxt_q.rdata = 8'h00;

    // Retire the latched source once the core has fetched its vector
    if (vector_taken) begin
      nxt_q.lat_vld = 1'b0;
    end else if (q_ff.lat_vld && !glob_mask && q_ff.lat_src != ELPC_SRC_TRAP
                 && q_ff.mode == ELPC_ST_RUN && !hw_act[q_ff.lat_src - 3'h1]) begin
      // Request withdrawn while unmasked: drop it rather than fetch a stale vector
      nxt_q.lat_vld = 1'b0;
    end

    unique case (q_ff.mode)
      // Run: break, boundary pick and low-power entry
      ELPC_ST_RUN: begin
        // Break needs no boundary and goes ahead of the boundary pick
        if (break_req && !nxt_q.lat_vld) begin
          nxt_q.lat_vld = 1'b1;
          nxt_q.lat_src = ELPC_SRC_TRAP;
          nxt_q.brk_st = 1'b1;
          nxt_q.pc_m1 = 1'b1;
        end else if (instr_done && !nxt_q.lat_vld) begin
          // Return completion is a boundary too, so a waiting request goes first
          if (trap_exec) begin
            nxt_q.lat_vld = 1'b1;
            nxt_q.lat_src = ELPC_SRC_TRAP;
            nxt_q.pc_m1 = 1'b0;
          end else if (any_hw && !glob_mask) begin
            nxt_q.lat_vld = 1'b1;
            nxt_q.lat_src = hw_pick;
            nxt_q.pc_m1 = 1'b1;
          end
        end
        // Low-power entry; the mask clear is a one-cycle pulse to the core
        if (instr_done && wait_exec) begin
          nxt_q.mode = ELPC_ST_WAIT;
          nxt_q.mask_clr = 1'b1;
          nxt_q.core_en = 1'b0;
        end else if (instr_done && stop_exec) begin
          nxt_q.mode = ELPC_ST_STOP;
          nxt_q.mask_clr = 1'b1;
          nxt_q.core_en = 1'b0;
          nxt_q.periph_en = 1'b0;
          nxt_q.osc_on = 1'b0;
        end
      end
      // Wait: core parked, enabled request or break wakes it
      ELPC_ST_WAIT: begin
        // Peripherals stay clocked; the mask was cleared on entry
        if (break_req) begin
          nxt_q.lp_flag = 1'b1;
          nxt_q.lat_vld = 1'b1;
          nxt_q.lat_src = ELPC_SRC_TRAP;
          nxt_q.brk_st = 1'b1;
          nxt_q.pc_m1 = 1'b1;
          nxt_q.mode = ELPC_ST_RUN;
          nxt_q.core_en = 1'b1;
        end else if (any_hw) begin
          nxt_q.lat_vld = 1'b1;
          nxt_q.lat_src = hw_pick;
          nxt_q.pc_m1 = 1'b1;
          nxt_q.mode = ELPC_ST_RUN;
          nxt_q.core_en = 1'b1;
        end
      end
      // Stop: everything gated until a wake event
      ELPC_ST_STOP: begin
        if (break_req || any_hw) begin
          nxt_q.mode = ELPC_ST_RECOVER;
          nxt_q.brk_pend = break_req;
          if (break_req) begin
            nxt_q.lp_flag = 1'b1;
          end
        end
      end
      // Recover: oscillators back, core waits for the count
      ELPC_ST_RECOVER: begin
        // Oscillators restart first; stacking only after the count runs out
        nxt_q.osc_on = 1'b1;
        // A break in recovery is kept so the forced trap follows the count
        if (break_req) begin
          nxt_q.brk_pend = 1'b1;
          nxt_q.lp_flag = 1'b1;
        end
        if (rec_done_w) begin
          nxt_q.mode = ELPC_ST_RUN;
          nxt_q.core_en = 1'b1;
          nxt_q.periph_en = 1'b1;
          nxt_q.lat_vld = 1'b1;
          nxt_q.pc_m1 = 1'b1;
          nxt_q.brk_pend = 1'b0;
          if (q_ff.brk_pend || break_req) begin
            nxt_q.lat_src = ELPC_SRC_TRAP;
            nxt_q.brk_st = 1'b1;
          end else begin
            nxt_q.lat_src = hw_pick;
          end
        end
      end
    endcase

    // Break ends with the return out of the forced trap
    if (return_done && q_ff.brk_st && !nxt_q.lat_vld) begin
      nxt_q.brk_st = 1'b0;
    end

    // Software writes; pending registers are not writable
    if (reg_wr) begin
      unique case (reg_addr)
        `ELPC_OFS_BRK_CTL: nxt_q.clr_permit_bit = reg_wdata[`ELPC_BIT_CLR_PERMIT];
        `ELPC_OFS_OPT_ONE: begin
          nxt_q.short_rec = reg_wdata[`ELPC_BIT_SHORT_REC];
          nxt_q.wdog_dis = reg_wdata[`ELPC_BIT_WDOG_DIS];
        end
        `ELPC_OFS_LP_STAT: begin
          // Write one clears, but a break while the core sleeps in this cycle keeps it set
          if (reg_wdata[`ELPC_BIT_LP_BREAK] && !lp_set) begin
            nxt_q.lp_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Reads are pure; nothing changes state
    if (reg_rd) begin
      unique case (reg_addr)
        `ELPC_OFS_PEND_A: begin
          nxt_q.rdata[`ELPC_BIT_EXT_PIN] = src_req[0];
          nxt_q.rdata[`ELPC_BIT_CHAN0] = src_req[1];
          nxt_q.rdata[`ELPC_BIT_CHAN1] = src_req[2];
          nxt_q.rdata[`ELPC_BIT_OVERFLOW] = src_req[3];
        end
        `ELPC_OFS_PEND_B: nxt_q.rdata[`ELPC_BIT_KEYPAD] = src_req[4];
        `ELPC_OFS_PEND_C: nxt_q.rdata[`ELPC_BIT_CONV_DONE] = src_req[5];
        `ELPC_OFS_BRK_CTL: nxt_q.rdata[`ELPC_BIT_CLR_PERMIT] = q_ff.clr_permit_bit;
        `ELPC_OFS_OPT_ONE: begin
          nxt_q.rdata[`ELPC_BIT_SHORT_REC] = q_ff.short_rec;
          nxt_q.rdata[`ELPC_BIT_WDOG_DIS] = q_ff.wdog_dis;
        end
        `ELPC_OFS_LP_STAT: nxt_q.rdata[`ELPC_BIT_LP_BREAK] = q_ff.lp_flag;
        default: nxt_q.rdata = 8'h00;
      endcase
    end

    // Other modules gate every clear step on this, so a two-step clear
    // begun before break still cannot finish inside it
    nxt_q.permit = !nxt_q.brk_st || nxt_q.clr_permit_bit;
    nxt_q.wdog_act = !nxt_q.wdog_dis && nxt_q.mode != ELPC_ST_STOP;
    // Vector follows the latched code so both change together
    nxt_q.vec = vec_of(nxt_q.lat_src);
  end

  // Reset loads the reset vector directly, bypassing arbitration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_ff <= '0;
      q_ff.lat_src <= ELPC_SRC_RESET;
      q_ff.vec <= `ELPC_VEC_RESET;
      // Clocks run and clearing is allowed out of reset
      q_ff.core_en <= 1'b1;
      q_ff.periph_en <= 1'b1;
      q_ff.osc_on <= 1'b1;
      q_ff.permit <= 1'b1;
      q_ff.wdog_act <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Registered read data, zero outside its one cycle
  assign reg_rdata = q_ff.rdata;

  // Arbitration result and stacking hints to the core
  assign int_req = q_ff.lat_vld;
  assign int_src = q_ff.lat_src;
  assign vec_addr = q_ff.vec;
  assign stack_pc_minus_one = q_ff.pc_m1;
  assign stack_index_high = q_ff.brk_pend & 1'b0;

  // Low-power pulse and clock gates
  assign mask_clear = q_ff.mask_clr;
  assign core_clk_en = q_ff.core_en;
  assign periph_clk_en = q_ff.periph_en;
  assign osc_en = q_ff.osc_on;

  // Break state and the clear permit other modules gate on
  assign break_state = q_ff.brk_st;
  assign flag_clear_permit = q_ff.permit;

  // Watchdog runs except in stop, unless disabled
  assign watchdog_active = q_ff.wdog_act;

endmodule : elpc_exc_ctl
`default_nettype wire

// ---- tb/elpc_exc_ctl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module elpc_exc_ctl_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] src_req,
  input wire logic [5:0] src_en,
  input wire logic glob_mask,
  input wire logic instr_done,
  input wire logic trap_exec,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic vector_taken,
  input wire logic break_req,
  input wire logic int_req,
  input wire elpc_pkg::elpc_src_type int_src,
  input wire logic [15:0] vec_addr,
  input wire logic stack_pc_minus_one,
  input wire logic stack_index_high,
  input wire logic mask_clear,
  input wire logic core_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_en,
  input wire logic break_state,
  input wire logic flag_clear_permit
);
  import elpc_pkg::*;
  // Vector per arbitration code, indexed by the code itself
  localparam logic [15:0] VT [8] = '{16'hfffc, 16'hfffa, 16'hfff6, 16'hfff4,
                                     16'hfff2, 16'hffe0, 16'hffde, 16'hfffe};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_vec_map;
    int_req |-> vec_addr == VT[int_src];
  endproperty
  a_vec_map: assert property (p_vec_map)
    else $error("vector does not match code");
  property p_trap;
    instr_done && trap_exec && !break_req && !int_req && core_clk_en |=>
      int_req && int_src == ELPC_SRC_TRAP && !stack_pc_minus_one;
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap not taken");
  property p_masked;
    instr_done && glob_mask && !(trap_exec || wait_exec || stop_exec || break_req) &&
      !int_req && core_clk_en |=> !int_req;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked request taken");
  property p_keep;
    int_req && glob_mask && !vector_taken |=> int_req && $stable(int_src);
  endproperty
  a_keep: assert property (p_keep)
    else $error("latched request displaced");
  property p_retire;
    int_req && vector_taken && !instr_done && !break_req && core_clk_en |=> !int_req;
  endproperty
  a_retire: assert property (p_retire)
    else $error("request not retired");
  property p_no_idx;
    !stack_index_high;
  endproperty
  a_no_idx: assert property (p_no_idx)
    else $error("high index byte stacked");
  property p_wait_in;
    instr_done && wait_exec && core_clk_en |=>
      mask_clear && !core_clk_en && periph_clk_en ##1 !mask_clear;
  endproperty
  a_wait_in: assert property (p_wait_in)
    else $error("wait entry wrong");
  property p_stop_in;
    instr_done && stop_exec && core_clk_en |=>
      mask_clear && !core_clk_en && !periph_clk_en && !osc_en;
  endproperty
  a_stop_in: assert property (p_stop_in)
    else $error("stop entry wrong");
  property p_wake;
    !core_clk_en && periph_clk_en && (src_req & src_en) != 6'h00 && !int_req |=>
      int_req && core_clk_en;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wait wake late");
  property p_permit;
    !break_state |-> flag_clear_permit;
  endproperty
  a_permit: assert property (p_permit)
    else $error("clearing blocked outside break");
  property p_break_in;
    instr_done && break_req && !int_req && core_clk_en && !break_state |=>
      break_state && int_req && int_src == ELPC_SRC_TRAP;
  endproperty
  a_break_in: assert property (p_break_in)
    else $error("break entry wrong");
  property p_rd_zero;
    reg_rd && reg_addr == 3'h0 |=> (reg_rdata & 8'h8b) == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("unused bit set");
  c_wake: cover property (!core_clk_en && periph_clk_en ##1 int_req);
  c_stop: cover property (!osc_en ##1 osc_en);
  c_break: cover property ($rose(break_state));
endmodule : elpc_exc_ctl_assertions
bind elpc_exc_ctl elpc_exc_ctl_assertions chk_u (.*);
`default_nettype wire

// ---- tb/elpc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module elpc_core_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic int_req,
  input wire logic [7:0] ack_dly,
  output logic vector_taken
);
  logic [7:0] wait_ff;
  // Stack and fetch after a chosen stall, prompt or slow
  always_ff @(posedge clk) begin
    if (sys_rst || !int_req || vector_taken) begin
      wait_ff <= 8'h00;
      vector_taken <= 1'b0;
    end else begin
      wait_ff <= wait_ff + 8'h01;
      vector_taken <= (wait_ff == ack_dly);
    end
  end
endmodule : elpc_core_model
`default_nettype wire

// ---- tb/tb_exception_and_lowpower_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); \
  end \
end
module tb_exception_and_lowpower_control;
  import elpc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] src_req = 6'h00;
  logic [5:0] src_en = 6'h00;
  logic glob_mask = 1'b0;
  logic [4:0] op = 5'h00;
  logic break_req = 1'b0;
  logic [7:0] ack_dly = 8'h02;
  logic [7:0] reg_rdata;
  logic int_req, vector_taken, pcm1, idx_hi, mask_clr, core_en, per_en, osc_en, brk, permit, wdog;
  elpc_src_type int_src;
  logic [15:0] vec_addr;
  logic [7:0] rq[$];
  logic [19:0] eq[$];
  logic [19:0] ex;
  logic [5:0] r;
  logic rd_pend = 1'b0;
  logic irq_prev = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n = 0;
  logic [15:0] vt [6] = '{16'hfffa, 16'hfff6, 16'hfff4, 16'hfff2, 16'hffe0, 16'hffde};

  elpc_exc_ctl dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
    .src_en(src_en), .glob_mask(glob_mask), .instr_done(op[0]), .trap_exec(op[1]),
    .wait_exec(op[2]), .stop_exec(op[3]), .return_done(op[4]),
    .vector_taken(vector_taken), .break_req(break_req), .int_req(int_req),
    .int_src(int_src), .vec_addr(vec_addr), .stack_pc_minus_one(pcm1),
    .stack_index_high(idx_hi), .mask_clear(mask_clr), .core_clk_en(core_en),
    .periph_clk_en(per_en), .osc_en(osc_en), .break_state(brk),
    .flag_clear_permit(permit), .watchdog_active(wdog));
  elpc_core_model core_u (.clk(clk), .sys_rst(sys_rst), .int_req(int_req),
    .ack_dly(ack_dly), .vector_taken(vector_taken));

  always #4 clk = ~clk;

  // Cycle ceiling: two stop recoveries plus nearly 16000 cycles of slack for traffic
  always @(posedge clk) begin
    rd_pend <= reg_rd;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // Score read data and interrupt entries when they appear
  always @(negedge clk) begin
    if (rd_pend) begin
      ex = {12'h000, rq.pop_front()};
      `CHK(reg_rdata, ex[7:0])
    end
    if (int_req && !irq_prev) begin
      `CHK(eq.size() > 0, 1'b1)
      if (eq.size() > 0) begin
        ex = eq.pop_front();
        `CHK({int_src, vec_addr, pcm1}, ex)
      end
    end
    irq_prev = int_req;
  end

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  // One instruction end: f is {return, stop, wait, trap}
  task automatic ins(input logic [3:0] f, input logic b);
    op <= {f, 1'b1};
    break_req <= b;
    @(posedge clk);
    op <= 5'h00;
    break_req <= 1'b0;
    @(posedge clk);
  endtask : ins

  // Bounded wait for an entry to rise, then for the core to retire it
  task automatic serve(input int lim);
    n = 0;
    @(posedge clk);
    while (int_req !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    repeat (40) if (int_req === 1'b1) @(posedge clk);
    `CHK(int_req, 1'b0)
    src_req <= 6'h00;
    @(posedge clk);
  endtask : serve

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    n = $urandom(50);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK({int_req, int_src, vec_addr}, {1'b0, ELPC_SRC_RESET, 16'hfffe})
    `CHK({core_en, permit, idx_hi}, 3'b110)
    // Flags follow raw requests, writes bounce off
    repeat (6) begin
      r = 6'($urandom);
      src_req <= r;
      wr(3'h0, 8'hff);
      rd(3'h0, {1'b0, r[3:1], 1'b0, r[0], 2'b00});
      rd(3'h1, {r[4], 7'h00});
      rd(3'h2, {7'h00, r[5]});
      rd(3'h7, 8'h00);
    end
    src_en <= 6'h3f;
    // Each source beats every lower one, acknowledged at random pace
    for (int i = 0; i < 6; i++) begin
      r = 6'($urandom) | (6'h01 << i);
      src_req <= r & ~((6'h01 << i) - 6'h01);
      ack_dly <= 8'($urandom_range(0, 9));
      eq.push_back({3'(i + 1), vt[i], 1'b1});
      ins(4'h0, 1'b0);
      serve(10);
    end
    // Mask blocks hardware but never the trap
    glob_mask <= 1'b1;
    src_req <= 6'h3f;
    ins(4'h0, 1'b0);
    `CHK(int_req, 1'b0)
    eq.push_back({3'h0, 16'hfffc, 1'b0});
    ins(4'h1, 1'b0);
    serve(10);
    // Slow core: a later higher request must not displace the latched one
    glob_mask <= 1'b0;
    ack_dly <= 8'h14;
    src_req <= 6'h20;
    eq.push_back({3'h6, 16'hffde, 1'b1});
    ins(4'h0, 1'b0);
    src_req <= 6'h3f;
    ins(4'h0, 1'b0);
    `CHK(int_src, ELPC_SRC_CONV_DONE)
    serve(4);
    src_req <= 6'h02;
    eq.push_back({3'h2, 16'hfff6, 1'b1});
    ins(4'h8, 1'b0);
    serve(10);
    // Wait parks the core, peripherals keep running, a request wakes it
    glob_mask <= 1'b1;
    ack_dly <= 8'h01;
    ins(4'h2, 1'b0);
    `CHK({core_en, per_en, mask_clr, wdog}, 4'b0111)
    src_req <= 6'h04;
    eq.push_back({3'h3, 16'hfff4, 1'b1});
    serve(5);
    `CHK(core_en, 1'b1)
    // Stop recovery length follows the short select
    for (int s = 0; s < 2; s++) begin
      wr(3'h4, {6'h00, s[0], s[0]});
      rd(3'h4, {6'h00, s[0], s[0]});
      ins(4'h4, 1'b0);
      `CHK({osc_en, wdog, per_en, mask_clr}, 4'b0001)
      src_req <= 6'h01;
      eq.push_back({3'h1, 16'hfffa, 1'b1});
      serve(5000);
      `CHK(n >= (s ? 32 : 4096) && n <= (s ? 38 : 4102), 1'b1)
      `CHK(wdog, !s[0])
    end
    // Break guards flags until clearing is permitted
    wr(3'h3, 8'h00);
    eq.push_back({3'h0, 16'hfffc, 1'b1});
    ins(4'h0, 1'b1);
    `CHK({brk, permit}, 2'b10)
    wr(3'h3, 8'h80);
    rd(3'h3, 8'h80);
    `CHK(permit, 1'b1)
    serve(10);
    ins(4'h8, 1'b0);
    `CHK(brk, 1'b0)
    // Break during wait leaves the low-power flag, write one clears it
    ins(4'h2, 1'b0);
    eq.push_back({3'h0, 16'hfffc, 1'b1});
    break_req <= 1'b1;
    @(posedge clk);
    break_req <= 1'b0;
    serve(10);
    rd(3'h5, 8'h02);
    wr(3'h5, 8'h02);
    rd(3'h5, 8'h00);
    ins(4'h8, 1'b0);
    `CHK(eq.size() + rq.size(), 0)
    report_and_stop();
  end
endmodule : tb_exception_and_lowpower_control
`default_nettype wire
